// file: rtl/omc_operating_mode_controller.sv
// Operating mode controller: run, debug halt, wait and two stop modes.
// Assumes CPU events and debug commands arrive as one-cycle pulses on clk_sys;
// the mode pin, reset pin and wake pin are asynchronous and synchronised here.
`timescale 1ns/1ps
`default_nettype none
module omc_operating_mode_controller #(
	parameter int PIN_W = 8 // Latched I/O pin count.
) (
	input wire logic clk_sys, // System clock.
	input wire logic sys_rst, // Asynchronous reset, active high.
	input wire logic mode_select_debug_pin_in, // Mode pin level.
	input wire logic reset_pin_n, // External reset pin, active low.
	input wire logic ext_irq_pin_n, // External interrupt pin, active low in deep stop.
	input wire omc_pkg::omc_cpu_ev_t cpu_ev, // CPU instruction events.
	input wire omc_pkg::omc_wake_t wake_src, // Interrupt sources.
	input wire logic irq_pending, // Any interrupt request to the CPU.
	input wire omc_pkg::omc_cmd_t dbg_cmd, // Debug command strobe class.
	input wire logic stop_enable_bit, // Stop allowed.
	input wire logic deep_stop_select, // Deep stop requested.
	input wire logic lowvolt_detect_enable, // Low-voltage detector on.
	input wire logic lowvolt_in_stop_enable, // Low-voltage detector kept in stop.
	input wire logic debug_in_stop_enable, // Debug clocks kept in stop.
	input wire logic pin_latch_release, // Write strobe with data of release bit.
	input wire logic [PIN_W-1:0] pin_ctrl_state, // Current port or peripheral pin drive.
	output logic [2:0] mode_state, // Current mode code.
	output logic cpu_clk_en, // CPU clock running.
	output logic fetch_en, // CPU may fetch application code.
	output logic vector_fetch, // Pulse: fetch vector.
	output logic [15:0] vector_addr, // Vector address when fetching reset vector.
	output logic clear_int_mask, // Pulse: clear interrupt mask bit.
	output logic illegal_op_reset, // Pulse: forced illegal-opcode reset.
	output logic por_restart, // Pulse: restart as power-on.
	output logic cmd_accept, // Pulse: command accepted.
	output logic cmd_stop_err, // Pulse: stop-or-wait error answer.
	output logic clocks_on, // Internal clocks running.
	output logic debug_clk_on, // Debug logic clocked.
	output logic power_down, // Regulated circuits except RAM off.
	output logic reg_standby, // Regulator and converter in standby.
	output logic [PIN_W-1:0] pin_out, // Pins after latch.
	output logic pin_latched, // Pin latches closed.
	output logic deep_stop_wake_flag, // Wake from deep stop seen.
	output logic pin_latch_release_rd // Release bit read value.
);
	omc_pkg::omc_mode_t mode_reg, mode_next;
	logic [omc_pkg::OMC_SYNC_W-1:0] ms_sync_reg, rp_sync_reg, irq_sync_reg;
	logic ms_reg, rp_n_reg, irq_n_reg;
	logic [2:0] boot_cnt_reg;
	logic [PIN_W-1:0] pin_hold_reg;
	logic latch_reg, flag_reg;

	// Three-stage synchronisers; a level counts once stages two and three agree.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ms_sync_reg <= 3'h7;
			rp_sync_reg <= 3'h7;
			irq_sync_reg <= 3'h7;
		end else begin
			ms_sync_reg <= {ms_sync_reg[1:0], mode_select_debug_pin_in};
			rp_sync_reg <= {rp_sync_reg[1:0], reset_pin_n};
			irq_sync_reg <= {irq_sync_reg[1:0], ext_irq_pin_n};
		end
	end

	function automatic logic agreed(input logic [2:0] s, input logic prev);
		agreed = (s[1] == s[2]) ? s[2] : prev;
	endfunction : agreed

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ms_reg <= 1'h1;
			rp_n_reg <= 1'h1;
			irq_n_reg <= 1'h1;
		end else begin
			ms_reg <= agreed(ms_sync_reg, ms_reg);
			rp_n_reg <= agreed(rp_sync_reg, rp_n_reg);
			irq_n_reg <= agreed(irq_sync_reg, irq_n_reg);
		end
	end

	// Decodes.
	wire is_run = (mode_reg == omc_pkg::OMC_RUN);
	wire is_halt = (mode_reg == omc_pkg::OMC_HALT);
	wire is_wait = (mode_reg == omc_pkg::OMC_WAIT);
	wire is_lstop = (mode_reg == omc_pkg::OMC_LSTOP);
	wire is_dstop = (mode_reg == omc_pkg::OMC_DSTOP);
	wire is_reset = (mode_reg == omc_pkg::OMC_RESET);
	wire boot_done = (boot_cnt_reg == '0);
	wire boot_ready = is_reset && boot_done;
	// Reset pin low reloads the count; otherwise it runs down to zero and rests there.
	wire [2:0] boot_cnt_next = !rp_n_reg ? omc_pkg::OMC_BOOT_HOLD
		: (boot_done ? boot_cnt_reg : boot_cnt_reg - 3'h1);
	wire cmd_enter = (dbg_cmd == omc_pkg::OMC_CMD_ENTER);
	wire cmd_stat = (dbg_cmd == omc_pkg::OMC_CMD_MEM_STAT);
	wire cmd_nonintr = (dbg_cmd == omc_pkg::OMC_CMD_MEM) || cmd_stat
		|| (dbg_cmd == omc_pkg::OMC_CMD_DBGREG) || cmd_enter;
	wire cmd_active = (dbg_cmd == omc_pkg::OMC_CMD_CPUREG)
		|| (dbg_cmd == omc_pkg::OMC_CMD_TRACE) || (dbg_cmd == omc_pkg::OMC_CMD_RESUME);
	// Debug commands reach the stop modes only when the debug logic stays clocked.
	wire stopped = is_wait || (is_lstop && debug_in_stop_enable);
	wire halt_ev = cpu_ev.halt_ins || cpu_ev.ctrl_bkpt || cpu_ev.mod_bkpt || cmd_enter;
	wire lowvolt_stop = lowvolt_detect_enable && lowvolt_in_stop_enable;
	wire go_deep = deep_stop_select && stop_enable_bit && !lowvolt_stop && !debug_in_stop_enable;
	wire lwake = |wake_src;
	// deep stop wake, pin treated active low
	wire dwake = !irq_n_reg || wake_src.timer;
	wire release_wr = pin_latch_release;

	// Next mode selection.
	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			omc_pkg::OMC_RESET: begin
				if (boot_done)
					mode_next = ms_reg ? omc_pkg::OMC_RUN : omc_pkg::OMC_HALT;
			end
			omc_pkg::OMC_RUN: begin
				if (halt_ev)
					mode_next = omc_pkg::OMC_HALT;
				else if (cpu_ev.wait_ins)
					mode_next = omc_pkg::OMC_WAIT;
				else if (cpu_ev.stop_ins && stop_enable_bit)
					mode_next = go_deep ? omc_pkg::OMC_DSTOP : omc_pkg::OMC_LSTOP;
				else if (cpu_ev.stop_ins)
					mode_next = omc_pkg::OMC_RESET;
			end
			omc_pkg::OMC_WAIT: begin
				if (cmd_enter)
					mode_next = omc_pkg::OMC_HALT;
				else if (irq_pending)
					mode_next = omc_pkg::OMC_RUN;
			end
			omc_pkg::OMC_LSTOP: begin
				if (cmd_enter && debug_in_stop_enable)
					mode_next = omc_pkg::OMC_HALT;
				else if (lwake)
					mode_next = omc_pkg::OMC_RUN;
			end
			omc_pkg::OMC_DSTOP: begin
				if (dwake)
					mode_next = omc_pkg::OMC_RESET;
			end
			omc_pkg::OMC_HALT: begin
				if (dbg_cmd == omc_pkg::OMC_CMD_RESUME)
					mode_next = omc_pkg::OMC_RUN;
			end
			default: mode_next = omc_pkg::OMC_RESET;
		endcase
		// Reset pin overrides everything.
		if (!rp_n_reg)
			mode_next = omc_pkg::OMC_RESET;
	end

	// Mode register; the boot count keeps reset mode until the synchronised mode pin is valid,
	// otherwise the reset value of the synchroniser would always pick run mode.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			mode_reg <= omc_pkg::OMC_RESET;
			boot_cnt_reg <= omc_pkg::OMC_BOOT_HOLD;
		end else begin
			mode_reg <= mode_next;
			boot_cnt_reg <= boot_cnt_next;
		end
	end

	wire dstop_wake = is_dstop && (mode_next == omc_pkg::OMC_RESET);
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			latch_reg <= 1'h0;
			flag_reg <= 1'h0;
			pin_hold_reg <= '0;
		end else begin
			// A second deep stop before release keeps the pins already held.
			if (mode_next == omc_pkg::OMC_DSTOP && !is_dstop && !latch_reg)
				pin_hold_reg <= pin_ctrl_state;
			latch_reg <= (mode_next == omc_pkg::OMC_DSTOP) || (latch_reg && !release_wr);
			// A wake in the same cycle as the release write keeps the flag set.
			flag_reg <= dstop_wake || (flag_reg && !release_wr);
		end
	end

	// Registered outputs.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			mode_state <= 3'h0;
			cpu_clk_en <= 1'h0;
			fetch_en <= 1'h0;
			vector_fetch <= 1'h0;
			vector_addr <= 16'h0000;
			clear_int_mask <= 1'h0;
			illegal_op_reset <= 1'h0;
			por_restart <= 1'h0;
			cmd_accept <= 1'h0;
			cmd_stop_err <= 1'h0;
			clocks_on <= 1'h1;
			debug_clk_on <= 1'h1;
			power_down <= 1'h0;
			reg_standby <= 1'h0;
			pin_out <= '0;
			pin_latched <= 1'h0;
			deep_stop_wake_flag <= 1'h0;
			pin_latch_release_rd <= 1'h0;
		end else begin
			mode_state <= mode_next;
			cpu_clk_en <= (mode_next == omc_pkg::OMC_RUN) || (mode_next == omc_pkg::OMC_HALT);
			fetch_en <= (mode_next == omc_pkg::OMC_RUN);
			vector_fetch <= (boot_ready && ms_reg && rp_n_reg) || (is_lstop && lwake && rp_n_reg)
				|| (is_wait && irq_pending && !cmd_enter && rp_n_reg);
			vector_addr <= omc_pkg::OMC_RESET_VECTOR;
			clear_int_mask <= is_run && cpu_ev.wait_ins && !halt_ev;
			illegal_op_reset <= is_run && !halt_ev && !cpu_ev.wait_ins
				&& cpu_ev.stop_ins && !stop_enable_bit;
			por_restart <= dstop_wake;
			cmd_accept <= (is_run && cmd_nonintr) || (is_halt && (cmd_nonintr || cmd_active))
				|| (stopped && (cmd_enter || cmd_stat));
			cmd_stop_err <= stopped && cmd_stat;
			clocks_on <= !((mode_next == omc_pkg::OMC_LSTOP) || (mode_next == omc_pkg::OMC_DSTOP));
			debug_clk_on <= !((mode_next == omc_pkg::OMC_DSTOP)
				|| (mode_next == omc_pkg::OMC_LSTOP && !debug_in_stop_enable));
			power_down <= (mode_next == omc_pkg::OMC_DSTOP);
			reg_standby <= (mode_next == omc_pkg::OMC_DSTOP)
				|| (mode_next == omc_pkg::OMC_LSTOP && !debug_in_stop_enable && !lowvolt_stop);
			pin_out <= latch_reg ? pin_hold_reg : pin_ctrl_state;
			pin_latched <= latch_reg;
			deep_stop_wake_flag <= flag_reg;
			pin_latch_release_rd <= 1'h0;
		end
	end

	// Deep stop always lowers the regulator.
	pd_reg_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		power_down |-> reg_standby) else $error("deep stop without standby");
	// Illegal stop goes to reset.
	ill_stop_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		illegal_op_reset |-> mode_state == omc_pkg::OMC_RESET || !rp_n_reg)
		else $error("illegal stop");
	// Deep stop never chosen with debug in stop.
	deep_dbg_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(is_run && cpu_ev.stop_ins && debug_in_stop_enable && rp_n_reg && !halt_ev
		&& !cpu_ev.wait_ins) |=> mode_reg != omc_pkg::OMC_DSTOP) else $error("deep with debug");
	// Status command in wait errs.
	wait_err_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(is_wait && cmd_stat) |=> cmd_stop_err) else $error("no stop error");
	// Active commands refused in run.
	run_cmd_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(is_run && cmd_active) |=> !cmd_accept) else $error("active cmd in run");
	// Wait clears interrupt mask.
	wait_mask_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(is_run && cpu_ev.wait_ins && !halt_ev && rp_n_reg) |=> clear_int_mask && !cpu_clk_en)
		else $error("wait mask");
	// Flag holds until release.
	flag_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(flag_reg && !release_wr) |=> flag_reg) else $error("flag lost");
	// Latched pins hold.
	pin_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(latch_reg && $past(latch_reg)) |=> $stable(pin_out)) else $error("pins moved");
	// Release reads zero.
	rel_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!pin_latch_release_rd) else $error("release read one");
	// Mode pin high at boot gives run mode and a reset vector fetch.
	boot_run_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(boot_ready && rp_n_reg && ms_reg) |=> is_run && vector_fetch)
		else $error("boot not in run");
	// Mode pin low at boot gives debug halt.
	boot_halt_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(boot_ready && rp_n_reg && !ms_reg) |=> is_halt && !fetch_en)
		else $error("boot not in halt");
	// Debug halt never fetches application code.
	halt_fetch_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		is_halt |-> !fetch_en) else $error("fetch in halt");
	// An interrupt in wait restarts the CPU.
	wait_irq_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(is_wait && irq_pending && !cmd_enter && rp_n_reg) |=> is_run && vector_fetch)
		else $error("wait not left");
	// Deep stop is left only on its own wake sources.
	deep_stay_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(is_dstop && !dwake && rp_n_reg) |=> is_dstop) else $error("deep stop left");
	// A light stop wake source returns to run.
	lstop_wake_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(is_lstop && lwake && rp_n_reg && !(cmd_enter && debug_in_stop_enable)) |=> is_run)
		else $error("light stop not left");
	// Both stop modes halt the internal clocks.
	stop_clk_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(is_lstop || is_dstop) |-> !clocks_on) else $error("clocks in stop");
	dwake_c: cover property (@(posedge clk_sys) disable iff (sys_rst) dstop_wake);
	wake_c: cover property (@(posedge clk_sys) disable iff (sys_rst) is_wait ##1 is_run);
	halt_c: cover property (@(posedge clk_sys) disable iff (sys_rst) is_halt ##1 is_run);
	illegal_c: cover property (@(posedge clk_sys) disable iff (sys_rst) illegal_op_reset);
	lstop_c: cover property (@(posedge clk_sys) disable iff (sys_rst) is_lstop ##1 is_run);
endmodule : omc_operating_mode_controller
`default_nettype wire

// file: rtl/omc_pkg.sv
// Constants and carrier types for the operating mode controller.
// Assumes a single 200 MHz system clock and an active high asynchronous reset.
package omc_pkg;
	// Mode encodings, Gray along run, wait, light stop, deep stop.
	typedef enum logic [2:0] {
		OMC_RESET = 3'h0,
		OMC_RUN = 3'h1,
		OMC_WAIT = 3'h3,
		OMC_LSTOP = 3'h2,
		OMC_DSTOP = 3'h6,
		OMC_HALT = 3'h5
	} omc_mode_t;
	localparam logic [15:0] OMC_RESET_VECTOR = 16'hFFFE;
	// Debug command classes from the serial decoder.
	typedef enum logic [2:0] {
		OMC_CMD_NONE = 3'h0,
		OMC_CMD_MEM = 3'h1,
		OMC_CMD_MEM_STAT = 3'h2,
		OMC_CMD_DBGREG = 3'h3,
		OMC_CMD_ENTER = 3'h4,
		OMC_CMD_CPUREG = 3'h5,
		OMC_CMD_TRACE = 3'h6,
		OMC_CMD_RESUME = 3'h7
	} omc_cmd_t;
	// Instruction events from the CPU, one-cycle pulses.
	typedef struct packed {
		logic wait_ins;
		logic stop_ins;
		logic halt_ins;
		logic ctrl_bkpt;
		logic mod_bkpt;
	} omc_cpu_ev_t;
	// Light-stop wake sources.
	typedef struct packed {
		logic timer;
		logic lowvolt;
		logic adc;
		logic ext_irq;
		logic keypad;
	} omc_wake_t;
	localparam int OMC_SYNC_W = 3;
	// Cycles that reset mode is held after release, so the mode pin has crossed the synchroniser.
	localparam logic [2:0] OMC_BOOT_HOLD = 3'h4;
endpackage : omc_pkg

// file: bench/omc_debug_host.sv
// Debug host model: holds the mode pin and sends one-cycle command strobes.
// Assumes the bench calls its tasks just after a clock edge, from one process.
`timescale 1ns/1ps
`default_nettype none
module omc_debug_host (
	input wire logic clk_sys, // System clock.
	input wire logic [2:0] mode_state, // Device mode code.
	input wire logic cmd_accept, // Accept pulse from the device.
	input wire logic cmd_stop_err, // Stop-or-wait error pulse.
	output var omc_pkg::omc_cmd_t dbg_cmd, // Command strobe class.
	output var logic mode_pin // Mode select level.
);
	// The pin has a pull-up, so an idle host leaves it high.
	initial begin
		dbg_cmd = omc_pkg::OMC_CMD_NONE;
		mode_pin = 1'b1;
	end
	// Sets the level that the device samples at reset release.
	task automatic set_pin(input logic v);
		@(posedge clk_sys);
		mode_pin <= v;
	endtask : set_pin
	// strobes of any command class
	// Active commands go out only in debug halt, unless a refusal is wanted.
	task automatic send(input omc_pkg::omc_cmd_t c, input logic f, output logic a,
		output logic e);
		a = 1'b0;
		e = 1'b0;
		if (c < omc_pkg::OMC_CMD_CPUREG || f || mode_state === omc_pkg::OMC_HALT) begin
			@(posedge clk_sys);
			dbg_cmd <= c;
			@(posedge clk_sys);
			dbg_cmd <= omc_pkg::OMC_CMD_NONE;
			#1;
			a = cmd_accept;
			e = cmd_stop_err;
		end
	endtask : send
endmodule : omc_debug_host
`default_nettype wire

// file: bench/omc_operating_mode_controller_tb.sv
// Self-checking bench for the operating mode controller, one task per scenario except the illegal stop check, done inline in the main sequence.
// Assumes the debug host model drives the mode pin and the command strobes.
`timescale 1ns/1ps
`default_nettype none
module omc_operating_mode_controller_tb;
	localparam omc_pkg::omc_mode_t RUN = omc_pkg::OMC_RUN;
	localparam omc_pkg::omc_mode_t LS = omc_pkg::OMC_LSTOP;
	localparam omc_pkg::omc_mode_t HLT = omc_pkg::OMC_HALT;
	logic clk_sys, sys_rst, irq_n, irq_pend, st_en, ds_sel, lv_en, lv_st, dbg_st, rel;
	logic mpin, vf, cim, ilr, por, acc, err, cko, dko, pwd, stb, latd, flag, rd, cce, fen;
	logic a, e, rst_pin_n;
	logic [2:0] mode;
	logic [15:0] vaddr;
	logic [7:0] pctl, pout;
	omc_pkg::omc_cpu_ev_t ev;
	omc_pkg::omc_wake_t wk;
	omc_pkg::omc_cmd_t cmd;
	int n_mismatch = 0;
	int n_checks = 0;
	omc_debug_host host (.clk_sys(clk_sys), .mode_state(mode), .cmd_accept(acc),
		.cmd_stop_err(err), .dbg_cmd(cmd), .mode_pin(mpin));
	omc_operating_mode_controller #(.PIN_W(8)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.mode_select_debug_pin_in(mpin), .reset_pin_n(rst_pin_n), .ext_irq_pin_n(irq_n),
		.cpu_ev(ev), .wake_src(wk), .irq_pending(irq_pend), .dbg_cmd(cmd),
		.stop_enable_bit(st_en), .deep_stop_select(ds_sel), .lowvolt_detect_enable(lv_en),
		.lowvolt_in_stop_enable(lv_st), .debug_in_stop_enable(dbg_st),
		.pin_latch_release(rel), .pin_ctrl_state(pctl), .mode_state(mode),
		.cpu_clk_en(cce), .fetch_en(fen), .vector_fetch(vf), .vector_addr(vaddr),
		.clear_int_mask(cim), .illegal_op_reset(ilr), .por_restart(por),
		.cmd_accept(acc), .cmd_stop_err(err), .clocks_on(cko), .debug_clk_on(dko),
		.power_down(pwd), .reg_standby(stb), .pin_out(pout), .pin_latched(latd),
		.deep_stop_wake_flag(flag), .pin_latch_release_rd(rd));
	// Free-running 200 MHz clock.
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// Every comparison lands here, so the counts stay in one place.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step
	// The mode is sampled 1 ns after the edge that took the event.
	task automatic pulse(input logic [4:0] v);
		@(posedge clk_sys);
		ev <= omc_pkg::omc_cpu_ev_t'(v);
		@(posedge clk_sys);
		ev <= '0;
		#1;
	endtask : pulse
	// Async pins pass synchronisers, so the wait is bounded, not fixed.
	task automatic wait_mode(input logic [2:0] m);
		for (int i = 0; i < 20 && mode !== m; i++) step(1);
		chk(mode, m);
	endtask : wait_mode
	task automatic do_reset(input logic pin);
		host.set_pin(pin);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		#1;
	endtask : do_reset
	task automatic resume();
		host.send(omc_pkg::OMC_CMD_RESUME, 1'b0, a, e);
		chk(a, 1);
		wait_mode(RUN);
	endtask : resume
	task automatic boot_run();
		logic seen;
		logic [15:0] va;
		seen = 1'b0;
		va = '0;
		do_reset(1'b1);
		for (int i = 0; i < 20; i++) begin
			step(1);
			if (vf === 1'b1) begin
				seen = 1'b1;
				va = vaddr;
			end
		end
		chk(seen, 1);
		chk(va, omc_pkg::OMC_RESET_VECTOR);
		chk({mode, fen}, {RUN, 1'b1});
	endtask : boot_run
	task automatic boot_halt();
		do_reset(1'b0);
		wait_mode(HLT);
		chk(fen, 0);
		host.send(omc_pkg::OMC_CMD_CPUREG, 1'b0, a, e);
		chk(a, 1);
		host.set_pin(1'b1);
		resume();
	endtask : boot_halt
	// Halt instruction, both breakpoints, then the enter command.
	task automatic halt_events();
		for (int k = 0; k < 4; k++) begin
			if (k < 3) pulse(5'h04 >> k);
			else host.send(omc_pkg::OMC_CMD_ENTER, 1'b0, a, e);
			chk(mode, HLT);
			chk(fen, 0);
			resume();
		end
	endtask : halt_events
	task automatic run_cmds();
		for (int k = 1; k < 4; k++) begin
			host.send(omc_pkg::omc_cmd_t'(k), 1'b0, a, e);
			chk({a, e}, 2'b10);
		end
		host.send(omc_pkg::OMC_CMD_TRACE, 1'b1, a, e);
		chk({a, mode}, {1'b0, RUN});
	endtask : run_cmds
	task automatic wait_tests();
		pulse(5'h10);
		chk({mode, cce, cim}, {omc_pkg::OMC_WAIT, 2'b01});
		host.send(omc_pkg::OMC_CMD_MEM, 1'b1, a, e);
		chk(a, 0);
		host.send(omc_pkg::OMC_CMD_MEM_STAT, 1'b1, a, e);
		chk(e, 1);
		@(posedge clk_sys);
		irq_pend <= 1'b1;
		wait_mode(RUN);
		chk(cce, 1);
		@(posedge clk_sys);
		irq_pend <= 1'b0;
		pulse(5'h10);
		host.send(omc_pkg::OMC_CMD_ENTER, 1'b1, a, e);
		chk(mode, HLT);
		resume();
	endtask : wait_tests
	task automatic light(input logic [3:0] cfg, input int w);
		@(posedge clk_sys);
		{st_en, ds_sel, lv_en, lv_st, dbg_st} <= {1'b1, cfg};
		pulse(5'h08);
		chk(mode, LS);
		chk({cko, dko}, {1'b0, cfg[0]});
		@(posedge clk_sys);
		wk <= omc_pkg::omc_wake_t'(5'h10 >> w);
		wait_mode(RUN);
		@(posedge clk_sys);
		wk <= '0;
	endtask : light
	task automatic deep(input logic by_pin);
		logic seen;
		seen = 1'b0;
		@(posedge clk_sys);
		{st_en, ds_sel, lv_en, lv_st, dbg_st, pctl} <= {5'h18, 8'hA5};
		pulse(5'h08);
		chk(mode, omc_pkg::OMC_DSTOP);
		@(posedge clk_sys);
		pctl <= 8'h3C;
		step(3);
		chk({pwd, stb, latd, pout}, {3'h7, 8'hA5});
		@(posedge clk_sys);
		if (by_pin) irq_n <= 1'b0;
		else wk <= omc_pkg::omc_wake_t'(5'h10);
		for (int i = 0; i < 20; i++) begin
			step(1);
			if (por === 1'b1) seen = 1'b1;
		end
		chk(seen, 1);
		@(posedge clk_sys);
		{irq_n, wk} <= {1'b1, 5'h00};
		wait_mode(RUN);
		step(5);
		chk({flag, latd, pout, rd}, {2'b11, 8'hA5, 1'b0});
		@(posedge clk_sys);
		rel <= 1'b1;
		@(posedge clk_sys);
		rel <= 1'b0;
		step(2);
		chk({flag, latd, pout, rd}, {2'b00, 8'h3C, 1'b0});
	endtask : deep
	// Reset pin taken low in light stop, then released: reboot through the reset vector.
	task automatic pin_reset();
		logic seen;
		seen = 1'b0;
		@(posedge clk_sys);
		{st_en, ds_sel, dbg_st} <= 3'h4;
		pulse(5'h08);
		chk(mode, LS);
		@(posedge clk_sys);
		rst_pin_n <= 1'b0;
		wait_mode(omc_pkg::OMC_RESET);
		@(posedge clk_sys);
		rst_pin_n <= 1'b1;
		for (int i = 0; i < 20; i++) begin
			step(1);
			if (vf === 1'b1) seen = 1'b1;
		end
		chk({seen, mode}, {1'b1, RUN});
	endtask : pin_reset
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : complete_run
	// Main sequence; every input has a value at time zero.
	initial begin
		{sys_rst, irq_n, irq_pend, st_en, ds_sel, lv_en, lv_st, dbg_st, rel} = 9'h180;
		rst_pin_n = 1'b1;
		{ev, wk, pctl} = '0;
		boot_run();
		boot_halt();
		halt_events();
		run_cmds();
		wait_tests();
		@(posedge clk_sys);
		{st_en, ds_sel} <= 2'b01;
		pulse(5'h08);
		chk({ilr, mode !== LS}, 2'b11);
		wait_mode(RUN);
		light(4'h0, 4);
		light(4'hE, 1);
		light(4'h9, 0);
		light(4'h0, 2);
		light(4'h0, 3);
		pin_reset();
		deep(1'b1);
		deep(1'b0);
		complete_run();
	end
	// The scenarios need a few hundred cycles; this bound of 40000 cycles catches a hang.
	initial begin
		#200000;
		n_mismatch++;
		complete_run();
	end
endmodule : omc_operating_mode_controller_tb
`default_nettype wire
